// ### hdl/cdg_countdown_guard.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// How it works
// (R1) software configures fully, then triggers start
// (R2) setup registers frozen while running
// (R3) down-counter; expiry on a tick at zero, which reloads it
// (R4) start loads counter with reload value
// (R5) granted reload reloads the counter
// (R6) expiry after reload value plus one ticks
// (R7) request RC oscillator while running with no slow source
// (R8) eight reload request registers, individually enabled
// (R9) reload only after key in all enabled
// (R10) counting continues during CPU sleep by default
// (R11) optional pause on sleep and debug halt
// (R12) power-off mode stops and disables it
// (R13) every expiry raises a reset request; a stop or power-off during the irq delay cancels it
// (R14) irq enabled delays reset two slow ticks
// (R15) pending reset survives reload, not stop
// (R16) reset reopens setup registers for writes
// (R17) stop ignored unless stop permit set
// (R18) stop needs permit, unlock key, trigger
// (R19) stop halts counter, flags, unblocks setup
// (R20) software clears unlock key after stop
// (R21) channel link: index low, enable bit 31
// (R22) enable set/clear registers, zero no effect
// (R23) decrement once per slow clock rising edge
// (R24) event flags sticky until zero written
module cdg_countdown_guard
  import cdg_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [11:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic SLOW_CLK,
  input wire logic SLOW_SOURCE_ACTIVE,
  output logic RC_OSC_REQ,
  input wire logic CPU_SLEEP,
  input wire logic DEBUG_HALT,
  input wire logic POWER_OFF,
  input wire logic [CDG_NUM_CHANNELS-1:0] CHAN_IN,
  output cdg_pub_t EXPIRY_PUB,
  output cdg_pub_t HALTED_PUB,
  output logic GUARD_RESET_REQ
);

  // ************************************************************
  // state
  // ************************************************************
  logic running_q, running_d;
  logic [31:0] count_q, count_d;
  logic [31:0] reload_value_q, reload_value_d;
  logic [CDG_NUM_RELOAD_REQ-1:0] rr_enable_q, rr_enable_d;
  logic [2:0] setup_q, setup_d;
  logic [31:0] unlock_key_q, unlock_key_d;
  logic [CDG_NUM_RELOAD_REQ-1:0] keyed_q, keyed_d;
  cdg_link_t start_link_q, start_link_d;
  cdg_link_t halt_link_q, halt_link_d;
  cdg_link_t expiry_out_q, expiry_out_d;
  cdg_link_t halted_out_q, halted_out_d;
  logic [1:0] irq_en_q, irq_en_d;
  logic [1:0] nmi_en_q, nmi_en_d;
  logic expiry_flag_q, expiry_flag_d;
  logic halted_flag_q, halted_flag_d;
  logic pending_q, pending_d;
  logic [1:0] delay_q, delay_d;
  logic reset_req_q, reset_req_d;
  cdg_pub_t expiry_pub_q, expiry_pub_d;
  cdg_pub_t halted_pub_q, halted_pub_d;
  logic [31:0] rdata_q, rdata_d;

  // ************************************************************
  // slow clock and task sources
  // ************************************************************
  logic slow_tick;
  logic start_chan_fire;
  logic halt_chan_fire;

  cdg_sync_rise u_slow_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .pin(SLOW_CLK),
    .rise(slow_tick)
  );

  cdg_chan_trigger u_start_chan (
    .link(start_link_q),
    .chan(CHAN_IN),
    .fire(start_chan_fire)
  );

  cdg_chan_trigger u_halt_chan (
    .link(halt_link_q),
    .chan(CHAN_IN),
    .fire(halt_chan_fire)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  wire sel_start = REG_ADDR == CDG_OFS_START_TRIGGER;
  wire sel_halt = REG_ADDR == CDG_OFS_HALT_TRIGGER;
  wire sel_start_link = REG_ADDR == CDG_OFS_START_CHANNEL_LINK;
  wire sel_halt_link = REG_ADDR == CDG_OFS_HALT_CHANNEL_LINK;
  wire sel_expiry_flag = REG_ADDR == CDG_OFS_EXPIRY_FLAG;
  wire sel_halted_flag = REG_ADDR == CDG_OFS_HALTED_FLAG;
  wire sel_expiry_out = REG_ADDR == CDG_OFS_EXPIRY_CHANNEL_OUT;
  wire sel_halted_out = REG_ADDR == CDG_OFS_HALTED_CHANNEL_OUT;
  wire sel_irq_set = REG_ADDR == CDG_OFS_IRQ_ENABLE_SET;
  wire sel_irq_clr = REG_ADDR == CDG_OFS_IRQ_ENABLE_CLEAR;
  wire sel_nmi_set = REG_ADDR == CDG_OFS_NONMASKABLE_ENABLE_SET;
  wire sel_nmi_clr = REG_ADDR == CDG_OFS_NONMASKABLE_ENABLE_CLEAR;
  wire sel_run = REG_ADDR == CDG_OFS_RUNNING_STATE;
  wire sel_pend = REG_ADDR == CDG_OFS_RELOAD_PENDING_STATE;
  wire sel_reload = REG_ADDR == CDG_OFS_RELOAD_VALUE;
  wire sel_rr_en = REG_ADDR == CDG_OFS_RELOAD_REQUEST_ENABLE;
  wire sel_setup = REG_ADDR == CDG_OFS_BEHAVIOUR_SETUP;
  wire sel_unlock = REG_ADDR == CDG_OFS_STOP_UNLOCK_KEY;

  logic [CDG_NUM_RELOAD_REQ-1:0] key_hit;
  genvar gi;
  generate
    for (gi = 0; gi < CDG_NUM_RELOAD_REQ; gi++) begin : g_rr
      localparam logic [11:0] RR_OFS =
        CDG_OFS_RELOAD_REQUEST_0 + CDG_OFS_RELOAD_REQUEST_STRIDE * 12'(gi);
      // only the key counts; any other value is dropped silently
      assign key_hit[gi] = REG_WR & (REG_ADDR == RR_OFS)
                           & (REG_WDATA == CDG_ACCESS_KEY); // (R8)
    end
  endgenerate

  // ************************************************************
  // control decisions
  // ************************************************************
  wire setup_open = ~running_q; // (R2)
  wire start_task = (REG_WR & sel_start & REG_WDATA[0]) | start_chan_fire;
  wire halt_task = (REG_WR & sel_halt & REG_WDATA[0]) | halt_chan_fire;
  wire stop_ok = running_q & halt_task & setup_q[CDG_CFG_STOP_PERMIT_BIT]
                 & (unlock_key_q == CDG_ACCESS_KEY); // (R17) (R18)
  wire paused = (setup_q[CDG_CFG_SLEEP_PAUSE_BIT] & CPU_SLEEP)
                | (setup_q[CDG_CFG_HALT_PAUSE_BIT] & DEBUG_HALT); // (R10) (R11)
  wire count_step = running_q & ~paused & slow_tick; // (R23)
  wire expiry = count_step & (count_q == 32'h0); // (R3) (R6)
  wire [CDG_NUM_RELOAD_REQ-1:0] keyed_all = keyed_q | (key_hit & rr_enable_q);
  // with nothing enabled a reload can never be granted
  wire grant = running_q & (|rr_enable_q)
               & ((keyed_all & rr_enable_q) == rr_enable_q); // (R9)
  wire halt_event = stop_ok;

  // ************************************************************
  // counter and run state
  // ************************************************************
  always_comb begin
    running_d = running_q;
    count_d = count_q;
    keyed_d = running_q ? keyed_all : '0;
    if (POWER_OFF) begin
      running_d = 1'b0; // (R12)
      keyed_d = '0;
    end else if (stop_ok) begin
      running_d = 1'b0; // (R19)
      keyed_d = '0;
    end else if (!running_q && start_task) begin
      running_d = 1'b1;
      count_d = reload_value_q; // (R4)
    end else if (grant) begin
      count_d = reload_value_q; // (R5)
      keyed_d = '0;
    end else if (expiry) begin
      count_d = reload_value_q;
    end else if (count_step) begin
      count_d = count_q - 32'h1; // (R23)
    end
  end

  // ************************************************************
  // expiry to reset request
  // ************************************************************
  always_comb begin
    pending_d = pending_q;
    delay_d = delay_q;
    reset_req_d = reset_req_q;
    if (stop_ok || POWER_OFF) begin
      pending_d = 1'b0; // (R15)
      delay_d = 2'h0;
    end else if (expiry && !pending_q) begin
      if (irq_en_q[CDG_IRQ_EXPIRY_BIT]) begin
        pending_d = 1'b1; // (R14)
        delay_d = 2'h0;
      end else begin
        reset_req_d = 1'b1; // (R13)
      end
    end else if (pending_q && slow_tick) begin
      // reload does not touch this path
      if (delay_q == CDG_RESET_DELAY_TICKS - 2'h1) begin
        pending_d = 1'b0;
        reset_req_d = 1'b1; // (R14) (R15)
      end else begin
        delay_d = delay_q + 2'h1;
      end
    end
  end

  // ************************************************************
  // register writes
  // ************************************************************
  always_comb begin
    reload_value_d = reload_value_q;
    rr_enable_d = rr_enable_q;
    setup_d = setup_q;
    unlock_key_d = unlock_key_q;
    start_link_d = start_link_q;
    halt_link_d = halt_link_q;
    expiry_out_d = expiry_out_q;
    halted_out_d = halted_out_q;
    irq_en_d = irq_en_q;
    nmi_en_d = nmi_en_q;
    if (REG_WR) begin
      if (sel_reload && setup_open) begin
        reload_value_d = REG_WDATA; // (R2)
      end
      if (sel_rr_en && setup_open) begin
        rr_enable_d = REG_WDATA[CDG_NUM_RELOAD_REQ-1:0]; // (R2)
      end
      if (sel_setup && setup_open) begin
        setup_d = REG_WDATA[2:0]; // (R2)
      end
      if (sel_unlock) begin
        unlock_key_d = REG_WDATA;
      end
      if (sel_start_link) begin
        start_link_d = {REG_WDATA[CDG_LINK_EN_BIT], REG_WDATA[CDG_CHAN_IDX_W-1:0]}; // (R21)
      end
      if (sel_halt_link) begin
        halt_link_d = {REG_WDATA[CDG_LINK_EN_BIT], REG_WDATA[CDG_CHAN_IDX_W-1:0]}; // (R21)
      end
      if (sel_expiry_out) begin
        expiry_out_d = {REG_WDATA[CDG_LINK_EN_BIT], REG_WDATA[CDG_CHAN_IDX_W-1:0]};
      end
      if (sel_halted_out) begin
        halted_out_d = {REG_WDATA[CDG_LINK_EN_BIT], REG_WDATA[CDG_CHAN_IDX_W-1:0]};
      end
      if (sel_irq_set) begin
        irq_en_d = irq_en_q | REG_WDATA[1:0]; // (R22)
      end
      if (sel_irq_clr) begin
        irq_en_d = irq_en_q & ~REG_WDATA[1:0]; // (R22)
      end
      if (sel_nmi_set) begin
        nmi_en_d = nmi_en_q | REG_WDATA[1:0]; // (R22)
      end
      if (sel_nmi_clr) begin
        nmi_en_d = nmi_en_q & ~REG_WDATA[1:0]; // (R22)
      end
    end
  end

  // ************************************************************
  // event flags and publishing
  // ************************************************************
  wire expiry_clr = REG_WR & sel_expiry_flag & ~REG_WDATA[0];
  wire halted_clr = REG_WR & sel_halted_flag & ~REG_WDATA[0];

  // set beats a clear landing in the same cycle
  assign expiry_flag_d = expiry | (expiry_flag_q & ~expiry_clr); // (R24)
  assign halted_flag_d = halt_event | (halted_flag_q & ~halted_clr); // (R19) (R24)
  assign expiry_pub_d = '{valid: expiry & expiry_out_q.en, idx: expiry_out_q.idx};
  assign halted_pub_d = '{valid: halt_event & halted_out_q.en, idx: halted_out_q.idx};

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    rdata_d = 32'h0;
    if (REG_RD) begin
      unique case (1'b1)
        sel_start_link: rdata_d = {start_link_q.en, 23'h0, start_link_q.idx};
        sel_halt_link: rdata_d = {halt_link_q.en, 23'h0, halt_link_q.idx};
        sel_expiry_flag: rdata_d = {31'h0, expiry_flag_q};
        sel_halted_flag: rdata_d = {31'h0, halted_flag_q};
        sel_expiry_out: rdata_d = {expiry_out_q.en, 23'h0, expiry_out_q.idx};
        sel_halted_out: rdata_d = {halted_out_q.en, 23'h0, halted_out_q.idx};
        sel_irq_set, sel_irq_clr: rdata_d = {30'h0, irq_en_q};
        sel_nmi_set, sel_nmi_clr: rdata_d = {30'h0, nmi_en_q};
        sel_run: rdata_d = {31'h0, running_q};
        sel_pend: rdata_d = {24'h0, rr_enable_q & ~keyed_q};
        sel_reload: rdata_d = reload_value_q;
        sel_rr_en: rdata_d = {24'h0, rr_enable_q};
        sel_setup: rdata_d = {29'h0, setup_q};
        sel_unlock: rdata_d = unlock_key_q;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // ************************************************************
  // flops
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      running_q <= 1'b0;
      count_q <= 32'h0;
      reload_value_q <= CDG_RELOAD_VALUE_RST; // (R16)
      rr_enable_q <= CDG_RELOAD_REQUEST_ENABLE_RST;
      setup_q <= CDG_BEHAVIOUR_SETUP_RST;
      unlock_key_q <= 32'h0;
      keyed_q <= '0;
      start_link_q <= '0;
      halt_link_q <= '0;
      expiry_out_q <= '0;
      halted_out_q <= '0;
      irq_en_q <= 2'h0;
      nmi_en_q <= 2'h0;
    end else begin
      running_q <= running_d;
      count_q <= count_d;
      reload_value_q <= reload_value_d;
      rr_enable_q <= rr_enable_d;
      setup_q <= setup_d;
      unlock_key_q <= unlock_key_d;
      keyed_q <= keyed_d;
      start_link_q <= start_link_d;
      halt_link_q <= halt_link_d;
      expiry_out_q <= expiry_out_d;
      halted_out_q <= halted_out_d;
      irq_en_q <= irq_en_d;
      nmi_en_q <= nmi_en_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      expiry_flag_q <= 1'b0;
      halted_flag_q <= 1'b0;
      pending_q <= 1'b0;
      delay_q <= 2'h0;
      reset_req_q <= 1'b0;
      expiry_pub_q <= '0;
      halted_pub_q <= '0;
      rdata_q <= 32'h0;
    end else begin
      expiry_flag_q <= expiry_flag_d;
      halted_flag_q <= halted_flag_d;
      pending_q <= pending_d;
      delay_q <= delay_d;
      reset_req_q <= reset_req_d;
      expiry_pub_q <= expiry_pub_d;
      halted_pub_q <= halted_pub_d;
      rdata_q <= rdata_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // source status comes from the clock controller on this clock
  assign RC_OSC_REQ = running_q & ~SLOW_SOURCE_ACTIVE; // (R7)
  assign GUARD_RESET_REQ = reset_req_q; // (R13)
  assign EXPIRY_PUB = expiry_pub_q;
  assign HALTED_PUB = halted_pub_q;
  assign REG_RDATA = rdata_q;

endmodule : cdg_countdown_guard

// ### hdl/cdg_pkg.sv
package cdg_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] CDG_OFS_START_TRIGGER = 12'h000;
  localparam logic [11:0] CDG_OFS_HALT_TRIGGER = 12'h004;
  localparam logic [11:0] CDG_OFS_START_CHANNEL_LINK = 12'h080;
  localparam logic [11:0] CDG_OFS_HALT_CHANNEL_LINK = 12'h084;
  localparam logic [11:0] CDG_OFS_EXPIRY_FLAG = 12'h100;
  localparam logic [11:0] CDG_OFS_HALTED_FLAG = 12'h104;
  localparam logic [11:0] CDG_OFS_EXPIRY_CHANNEL_OUT = 12'h180;
  localparam logic [11:0] CDG_OFS_HALTED_CHANNEL_OUT = 12'h184;
  localparam logic [11:0] CDG_OFS_IRQ_ENABLE_SET = 12'h304;
  localparam logic [11:0] CDG_OFS_IRQ_ENABLE_CLEAR = 12'h308;
  localparam logic [11:0] CDG_OFS_NONMASKABLE_ENABLE_SET = 12'h324;
  localparam logic [11:0] CDG_OFS_NONMASKABLE_ENABLE_CLEAR = 12'h328;
  localparam logic [11:0] CDG_OFS_RUNNING_STATE = 12'h400;
  localparam logic [11:0] CDG_OFS_RELOAD_PENDING_STATE = 12'h404;
  localparam logic [11:0] CDG_OFS_RELOAD_VALUE = 12'h504;
  localparam logic [11:0] CDG_OFS_RELOAD_REQUEST_ENABLE = 12'h508;
  localparam logic [11:0] CDG_OFS_BEHAVIOUR_SETUP = 12'h50c;
  localparam logic [11:0] CDG_OFS_STOP_UNLOCK_KEY = 12'h520;
  localparam logic [11:0] CDG_OFS_RELOAD_REQUEST_0 = 12'h600;
  localparam logic [11:0] CDG_OFS_RELOAD_REQUEST_STRIDE = 12'h004;

  // ************************************************************
  // field positions and values
  // ************************************************************
  localparam int CDG_NUM_RELOAD_REQ = 8;
  localparam int CDG_CHAN_IDX_W = 8;
  localparam int CDG_NUM_CHANNELS = 256;
  localparam int CDG_LINK_EN_BIT = 31;
  localparam int CDG_IRQ_EXPIRY_BIT = 0;
  localparam int CDG_IRQ_HALTED_BIT = 1;
  localparam int CDG_CFG_SLEEP_PAUSE_BIT = 0;
  localparam int CDG_CFG_HALT_PAUSE_BIT = 1;
  localparam int CDG_CFG_STOP_PERMIT_BIT = 2;
  localparam logic [31:0] CDG_ACCESS_KEY = 32'h6e524635;
  localparam logic [31:0] CDG_RELOAD_VALUE_RST = 32'hffffffff;
  localparam logic [7:0] CDG_RELOAD_REQUEST_ENABLE_RST = 8'h01;
  localparam logic [2:0] CDG_BEHAVIOUR_SETUP_RST = 3'h0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CDG_CLK_HZ = 100000000;
  localparam int CDG_SLOW_HZ = 32768;
  localparam logic [1:0] CDG_RESET_DELAY_TICKS = 2'h2;

  typedef struct packed {
    logic en;
    logic [CDG_CHAN_IDX_W-1:0] idx;
  } cdg_link_t;

  typedef struct packed {
    logic valid;
    logic [CDG_CHAN_IDX_W-1:0] idx;
  } cdg_pub_t;

endpackage : cdg_pkg

// ### hdl/cdg_sync_rise.sv
`timescale 1ns/1ps
module cdg_sync_rise
  import cdg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic rise
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // meta_q is seen only by sync_q
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
endmodule : cdg_sync_rise

// ### hdl/cdg_chan_trigger.sv
`timescale 1ns/1ps
module cdg_chan_trigger
  import cdg_pkg::*;
(
  input cdg_link_t link,
  input wire logic [CDG_NUM_CHANNELS-1:0] chan,
  output logic fire
);
  assign fire = link.en & chan[link.idx]; // (R21)
endmodule : cdg_chan_trigger

// ### tb/cdg_far_side_model.sv
`timescale 1ns/1ps
module cdg_far_side_model
  #(parameter int SLOW_HALF_NS = 200)
(
  input wire logic clk,
  input wire logic guard_reset_req,
  input wire logic src_on,
  output logic slow_clk,
  output logic slow_source_active,
  output logic wd_rst
);
  logic [3:0] req_q = 4'h0;

  // slow oscillator, sped up so runs stay short; odd offset keeps phase unrelated
  initial begin
    slow_clk = 1'b0;
    #37;
    forever #(SLOW_HALF_NS) slow_clk = ~slow_clk;
  end

  // reset controller answers a request four cycles late and drops reset four cycles after the request drops
  always @(posedge clk) begin
    req_q <= {req_q[2:0], guard_reset_req};
    slow_source_active <= src_on;
  end
  assign wd_rst = req_q[3];
endmodule : cdg_far_side_model

// ### tb/cdg_countdown_guard_properties.sv
`timescale 1ns/1ps
module cdg_countdown_guard_checker
  import cdg_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic SLOW_SOURCE_ACTIVE,
  input wire logic RC_OSC_REQ,
  input wire logic POWER_OFF,
  input cdg_pub_t EXPIRY_PUB,
  input cdg_pub_t HALTED_PUB,
  input wire logic GUARD_RESET_REQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // ************************************************************
  // pending reset age; two real slow ticks fit well under the limit
  // ************************************************************
  logic pend_q;
  logic [15:0] wait_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST || GUARD_RESET_REQ || POWER_OFF || HALTED_PUB.valid) begin
      pend_q <= 1'b0;
      wait_q <= 16'h0000;
    end else begin
      pend_q <= pend_q | EXPIRY_PUB.valid;
      wait_q <= pend_q ? wait_q + 16'h0001 : 16'h0000;
    end
  end

  // ************************************************************
  // properties
  // ************************************************************
  property p_rdata_idle;
    !$past(REG_RD) |-> REG_RDATA == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_osc_src;
    GUARD_RESET_REQ && !SLOW_SOURCE_ACTIVE |-> RC_OSC_REQ;
  endproperty
  a_osc_src: assert property (p_osc_src) else $error("oscillator idle while counting");
  property p_exp_osc;
    EXPIRY_PUB.valid && !SLOW_SOURCE_ACTIVE |-> RC_OSC_REQ;
  endproperty
  a_exp_osc: assert property (p_exp_osc) else $error("running without oscillator request");
  property p_req_hold;
    GUARD_RESET_REQ |=> GUARD_RESET_REQ;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("reset request dropped");
  property p_exp_req;
    wait_q < 16'h1f40;
  endproperty
  a_exp_req: assert property (p_exp_req) else $error("expiry not followed by reset");
  property p_exp_pulse;
    EXPIRY_PUB.valid |=> !EXPIRY_PUB.valid;
  endproperty
  a_exp_pulse: assert property (p_exp_pulse) else $error("expiry publish too long");
  property p_halt_stop;
    HALTED_PUB.valid |-> !RC_OSC_REQ;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("stopped but still running");
  property p_rose_req;
    $rose(GUARD_RESET_REQ) |-> !$past(POWER_OFF);
  endproperty
  a_rose_req: assert property (p_rose_req) else $error("reset issued in power off");
  property p_poweroff_osc;
    POWER_OFF |=> !RC_OSC_REQ;
  endproperty
  a_poweroff_osc: assert property (p_poweroff_osc) else $error("power off left it running");

  c_expiry: cover property (EXPIRY_PUB.valid);
  c_halted: cover property (HALTED_PUB.valid);
  c_reset: cover property ($rose(GUARD_RESET_REQ));
endmodule : cdg_countdown_guard_checker

bind cdg_countdown_guard cdg_countdown_guard_checker u_cdg_countdown_guard_checker (
  .CLK, .SYS_RST, .REG_RD, .REG_RDATA, .SLOW_SOURCE_ACTIVE, .RC_OSC_REQ, .POWER_OFF,
  .EXPIRY_PUB, .HALTED_PUB, .GUARD_RESET_REQ);

// ### tb/cdg_countdown_guard_tb.sv
`timescale 1ns/1ps
module cdg_countdown_guard_tb
  import cdg_pkg::*;
;
  localparam int SLOW_HALF_NS = 200;
  localparam int TICK_CYC = 2 * SLOW_HALF_NS / 10;
  localparam int LIMIT = 20000;
  logic CLK = 1'b0;
  logic bench_rst = 1'b1;
  logic SYS_RST;
  logic [11:0] REG_ADDR = 12'h000;
  logic [31:0] REG_WDATA = 32'h0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [31:0] REG_RDATA;
  logic SLOW_CLK, SLOW_SOURCE_ACTIVE, RC_OSC_REQ, GUARD_RESET_REQ, wd_rst;
  logic src_on = 1'b0;
  logic CPU_SLEEP = 1'b0;
  logic DEBUG_HALT = 1'b0;
  logic POWER_OFF = 1'b0;
  logic [CDG_NUM_CHANNELS-1:0] CHAN_IN = '0;
  cdg_pub_t EXPIRY_PUB, HALTED_PUB;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  // watchdog resets from the far side count as resets too
  assign SYS_RST = bench_rst | wd_rst;

  cdg_countdown_guard u_cdg_countdown_guard (.CLK, .SYS_RST, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA, .SLOW_CLK, .SLOW_SOURCE_ACTIVE, .RC_OSC_REQ, .CPU_SLEEP, .DEBUG_HALT,
    .POWER_OFF, .CHAN_IN, .EXPIRY_PUB, .HALTED_PUB, .GUARD_RESET_REQ);
  cdg_far_side_model #(.SLOW_HALF_NS(SLOW_HALF_NS)) u_cdg_far_side_model (.clk(CLK),
    .guard_reset_req(GUARD_RESET_REQ), .src_on(src_on), .slow_clk(SLOW_CLK),
    .slow_source_active(SLOW_SOURCE_ACTIVE), .wd_rst(wd_rst));

  initial begin
    forever #5 CLK = ~CLK;
  end

  // ************************************************************
  // bus and check tasks
  // ************************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA, exp);
  endtask : rd

  task automatic power_cut();
    @(posedge CLK);
    POWER_OFF <= 1'b1;
    @(posedge CLK);
    POWER_OFF <= 1'b0;
  endtask : power_cut

  // start just after a slow edge so the tick count is exact
  task automatic run_expiry(input logic [31:0] irq, input logic [31:0] exp_rises);
    int rises;
    int i;
    logic prev;
    logic fed;
    logic [7:0] idx;
    rises = 0;
    i = 0;
    fed = 1'b0;
    idx = 8'h00;
    wr(CDG_OFS_IRQ_ENABLE_SET, irq);
    wr(CDG_OFS_RELOAD_VALUE, 32'h3);
    wr(CDG_OFS_EXPIRY_CHANNEL_OUT, 32'h80000007);
    @(posedge SLOW_CLK);
    repeat (5) @(posedge CLK);
    wr(CDG_OFS_START_TRIGGER, 32'h1);
    prev = SLOW_CLK;
    while (GUARD_RESET_REQ !== 1'b1 && i < 20 * TICK_CYC) begin
      @(posedge CLK);
      #1;
      if (SLOW_CLK && !prev) rises++;
      prev = SLOW_CLK;
      if (EXPIRY_PUB.valid === 1'b1) idx = EXPIRY_PUB.idx;
      if (rises == 5 && !fed) begin
        fed = 1'b1;
        wr(CDG_OFS_RELOAD_REQUEST_0, CDG_ACCESS_KEY);
      end
      i++;
    end
    chk(32'(rises), exp_rises);
    chk({24'h0, idx}, 32'h7);
    repeat (10) @(posedge CLK);
    rd(CDG_OFS_RELOAD_VALUE, CDG_RELOAD_VALUE_RST);
    wr(CDG_OFS_RELOAD_VALUE, 32'h5);
    rd(CDG_OFS_RELOAD_VALUE, 32'h5);
  endtask : run_expiry

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (3) @(posedge CLK);
    bench_rst <= 1'b0;
    rd(CDG_OFS_RELOAD_VALUE, CDG_RELOAD_VALUE_RST);
    rd(CDG_OFS_RELOAD_REQUEST_ENABLE, 32'h1);
    rd(CDG_OFS_BEHAVIOUR_SETUP, 32'h0);
    rd(CDG_OFS_RUNNING_STATE, 32'h0);
    wr(12'h7fc, 32'hffffffff);
    rd(12'h7fc, 32'h0);
    $display("test reset_values done");
    wr(CDG_OFS_RELOAD_VALUE, 32'h3);
    wr(CDG_OFS_RELOAD_REQUEST_ENABLE, 32'h3);
    wr(CDG_OFS_BEHAVIOUR_SETUP, 32'h4);
    wr(CDG_OFS_HALTED_CHANNEL_OUT, 32'h80000002);
    wr(CDG_OFS_START_CHANNEL_LINK, 32'h80000005);
    rd(CDG_OFS_START_CHANNEL_LINK, 32'h80000005);
    @(posedge CLK);
    CHAN_IN[5] <= 1'b1;
    @(posedge CLK);
    CHAN_IN <= '0;
    rd(CDG_OFS_RUNNING_STATE, 32'h1);
    chk({31'h0, RC_OSC_REQ}, 32'h1);
    @(posedge CLK);
    src_on <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    chk({31'h0, RC_OSC_REQ}, 32'h0);
    wr(CDG_OFS_RELOAD_VALUE, 32'h9);
    rd(CDG_OFS_RELOAD_VALUE, 32'h3);
    wr(CDG_OFS_BEHAVIOUR_SETUP, 32'h0);
    rd(CDG_OFS_BEHAVIOUR_SETUP, 32'h4);
    wr(CDG_OFS_RELOAD_REQUEST_ENABLE, 32'h1);
    rd(CDG_OFS_RELOAD_REQUEST_ENABLE, 32'h3);
    rd(CDG_OFS_RELOAD_PENDING_STATE, 32'h3);
    wr(CDG_OFS_RELOAD_REQUEST_0, CDG_ACCESS_KEY);
    rd(CDG_OFS_RELOAD_PENDING_STATE, 32'h2);
    wr(CDG_OFS_RELOAD_REQUEST_0 + CDG_OFS_RELOAD_REQUEST_STRIDE, 32'h12345678);
    rd(CDG_OFS_RELOAD_PENDING_STATE, 32'h2);
    wr(CDG_OFS_RELOAD_REQUEST_0 + CDG_OFS_RELOAD_REQUEST_STRIDE, CDG_ACCESS_KEY);
    rd(CDG_OFS_RELOAD_PENDING_STATE, 32'h3);
    src_on <= 1'b0;
    wr(CDG_OFS_HALT_TRIGGER, 32'h1);
    rd(CDG_OFS_RUNNING_STATE, 32'h1);
    wr(CDG_OFS_STOP_UNLOCK_KEY, CDG_ACCESS_KEY);
    wr(CDG_OFS_HALT_TRIGGER, 32'h1);
    #1;
    chk({23'h0, HALTED_PUB}, 32'h102);
    rd(CDG_OFS_RUNNING_STATE, 32'h0);
    rd(CDG_OFS_HALTED_FLAG, 32'h1);
    wr(CDG_OFS_HALTED_FLAG, 32'h0);
    rd(CDG_OFS_HALTED_FLAG, 32'h0);
    wr(CDG_OFS_STOP_UNLOCK_KEY, 32'h0);
    wr(CDG_OFS_RELOAD_VALUE, 32'h9);
    rd(CDG_OFS_RELOAD_VALUE, 32'h9);
    $display("test start_feed_stop done");
    wr(CDG_OFS_IRQ_ENABLE_SET, 32'h1);
    wr(CDG_OFS_IRQ_ENABLE_CLEAR, 32'h0);
    rd(CDG_OFS_IRQ_ENABLE_SET, 32'h1);
    wr(CDG_OFS_IRQ_ENABLE_CLEAR, 32'h1);
    rd(CDG_OFS_IRQ_ENABLE_SET, 32'h0);
    wr(CDG_OFS_BEHAVIOUR_SETUP, 32'h0);
    wr(CDG_OFS_START_TRIGGER, 32'h1);
    wr(CDG_OFS_STOP_UNLOCK_KEY, CDG_ACCESS_KEY);
    wr(CDG_OFS_HALT_TRIGGER, 32'h1);
    rd(CDG_OFS_RUNNING_STATE, 32'h1);
    power_cut();
    rd(CDG_OFS_RUNNING_STATE, 32'h0);
    $display("test permit_power_off done");
    wr(CDG_OFS_BEHAVIOUR_SETUP, 32'h3);
    wr(CDG_OFS_RELOAD_VALUE, 32'h3);
    wr(CDG_OFS_IRQ_ENABLE_SET, 32'h1);
    @(posedge CLK);
    DEBUG_HALT <= 1'b1;
    wr(CDG_OFS_START_TRIGGER, 32'h1);
    repeat (4 * TICK_CYC) @(posedge CLK);
    DEBUG_HALT <= 1'b0;
    CPU_SLEEP <= 1'b1;
    repeat (4 * TICK_CYC) @(posedge CLK);
    rd(CDG_OFS_EXPIRY_FLAG, 32'h0);
    CPU_SLEEP <= 1'b0;
    repeat (9 * TICK_CYC / 2) @(posedge CLK);
    rd(CDG_OFS_EXPIRY_FLAG, 32'h1);
    power_cut();
    rd(CDG_OFS_RUNNING_STATE, 32'h0);
    wr(CDG_OFS_IRQ_ENABLE_CLEAR, 32'h1);
    wr(CDG_OFS_BEHAVIOUR_SETUP, 32'h0);
    $display("test pause done");
    CPU_SLEEP <= 1'b1;
    run_expiry(32'h0, 32'h4);
    run_expiry(32'h1, 32'h6);
    $display("test expiry done");
    print_verdict();
  end
endmodule : cdg_countdown_guard_tb
